/* core/scp_pkg.sv */
// Purpose: Shared constants for one serial channel pin block.
// Assumes: AXI4-Lite register access, 32-bit words, byte addresses.
// Notes: Offsets, field positions and reset values live here; the status read order is also written out in the channel.
package scp_pkg;
  localparam logic [7:0] OFS_DATA    = 8'h00;
  localparam logic [7:0] OFS_MODEM   = 8'h04;
  localparam logic [7:0] OFS_FEATURE = 8'h08;
  localparam logic [7:0] OFS_ALTFUNC = 8'h0c;
  localparam logic [7:0] OFS_DIVISOR = 8'h10;
  localparam logic [7:0] OFS_STATUS  = 8'h14;
  // Modem control fields.
  localparam int MC_DTR = 0;
  localparam int MC_RTS = 1;
  localparam int MC_OP2 = 3;
  localparam int MC_IR  = 6;
  // Feature control: infrared receive inversion.
  localparam int FC_IRINV = 2;
  // Alternate function control: selector in bits 2:1.
  localparam int AF_SEL_LO = 1;
  localparam logic [1:0] MF_OP2   = 2'h0;
  localparam logic [1:0] MF_BAUD  = 2'h1;
  localparam logic [1:0] MF_RXRDY = 2'h2;
  // Status fields.
  localparam int ST_RXV  = 0;
  localparam int ST_TXF  = 1;
  localparam int ST_TXB  = 2;
  localparam int ST_OVR  = 3;
  localparam int ST_MDM  = 4;
  // Reset values.
  localparam logic [7:0]  MODEM_RST   = 8'h00;
  localparam logic [7:0]  FEATURE_RST = 8'h00;
  localparam logic [7:0]  ALTFUNC_RST = 8'h00;
  localparam logic [15:0] DIVISOR_RST = 16'h000f;
  // Timing in 16x ticks; FRAME_BITS counts bits.
  localparam logic [3:0] TICKS_HALF = 4'h7;
  localparam logic [3:0] TICKS_LAST = 4'hf;
  localparam logic [3:0] IR_PULSE   = 4'h3;
  localparam logic [3:0] FRAME_BITS = 4'h9;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* core/scp_channel.sv */
// Purpose: Pin behaviour of one serial channel with an AXI4-Lite slave.
// Assumes: One 20 MHz clock; pins are asynchronous and synchronised here.
// Notes: Instantiate once per channel; 8N1 framing only.
`timescale 1ns/1ps
module scp_channel import scp_pkg::*; #(
  parameter int BUF_DEPTH = 2
) (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        arst_n,
  // AXI4-Lite slave.
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Serial and modem pins.
  input  wire logic        serial_in_chan_a,
  output logic             serial_out_chan_a,
  output logic             request_to_send_n_chan_a,
  output logic             terminal_ready_n_chan_a,
  input  wire logic        clear_to_send_n_chan_a,
  input  wire logic        set_ready_n_chan_a,
  input  wire logic        carrier_detect_n_chan_a,
  input  wire logic        ring_indicator_n_chan_a,
  output logic             multi_function_out_n_chan_a
);
  localparam int PW = $clog2(BUF_DEPTH);
  if (BUF_DEPTH < 2 || (1 << PW) != BUF_DEPTH) begin : g_chk
    $error("BUF_DEPTH must be a power of two, at least 2");
  end

  logic [7:0]  modem_control;
  logic [7:0]  feature_control;
  logic [7:0]  alternate_function_control;
  logic [15:0] divisor;
  logic        ir_sel;
  logic [1:0]  mf_sel;
  assign ir_sel = modem_control[MC_IR];
  assign mf_sel = alternate_function_control[AF_SEL_LO +: 2];

  // Pin synchronisers: stage one feeds stage two only.
  logic [4:0] pin_s1;
  logic [4:0] pin_s2;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_s1 <= 5'h1f;
      pin_s2 <= 5'h1f;
    end else begin
      pin_s1 <= {ring_indicator_n_chan_a, carrier_detect_n_chan_a,
                 set_ready_n_chan_a, clear_to_send_n_chan_a,
                 serial_in_chan_a};
      pin_s2 <= pin_s1;
    end
  end

  // Sixteen-times baud enable and the free-running baud clock.
  logic [15:0] bcnt;
  logic        tick16;
  logic        baud_clk;
  assign tick16 = (bcnt == 16'h0000);
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bcnt     <= 16'h0000;
      baud_clk <= 1'b0;
    end else begin
      bcnt     <= tick16 ? divisor : bcnt - 16'h0001;
      baud_clk <= (bcnt > (divisor >> 1));
    end
  end

  // Transmit holding register and shifter.
  logic [7:0] tx_hold;
  logic       tx_full;
  logic [9:0] tx_shift;
  logic [3:0] tx_bit;
  logic [3:0] tx_sub;
  logic       tx_busy;
  logic       tx_line;
  logic       wr_data;
  assign tx_line = tx_busy ? tx_shift[0] : 1'b1;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_full <= 1'b0;
      tx_hold <= 8'h00;
    end else if (wr_data && !tx_full) begin
      tx_full <= 1'b1;
      tx_hold <= w_byte;
    end else if (!tx_busy && tx_full && tick16) begin
      tx_full <= 1'b0;
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_busy  <= 1'b0;
      tx_shift <= 10'h3ff;
      tx_bit   <= 4'h0;
      tx_sub   <= 4'h0;
    end else if (tick16) begin
      if (!tx_busy) begin
        if (tx_full) begin
          tx_busy  <= 1'b1;
          tx_shift <= {1'b1, tx_hold, 1'b0};
          tx_bit   <= 4'h0;
          tx_sub   <= 4'h0;
        end
      end else if (tx_sub == TICKS_LAST) begin
        tx_sub   <= 4'h0;
        tx_shift <= {1'b1, tx_shift[9:1]};
        tx_bit   <= tx_bit + 4'h1;
        if (tx_bit == FRAME_BITS) begin
          tx_busy <= 1'b0;
        end
      end else begin
        tx_sub <= tx_sub + 4'h1;
      end
    end
  end
  // A zero bit is sent as a short high pulse in infrared mode.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      serial_out_chan_a <= 1'b1;
    end else if (ir_sel) begin
      serial_out_chan_a <= !tx_line && (tx_sub < IR_PULSE);
    end else begin
      serial_out_chan_a <= tx_line;
    end
  end

  // Infrared decoder: each pulse holds the line low until fifteen 16x ticks after it ends.
  logic       dec_in;
  logic [3:0] stretch;
  logic       rx_line;
  assign dec_in = feature_control[FC_IRINV] ? !pin_s2[0] : pin_s2[0];
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stretch <= 4'h0;
    end else if (dec_in) begin
      stretch <= TICKS_LAST;
    end else if (tick16 && stretch != 4'h0) begin
      stretch <= stretch - 4'h1;
    end
  end
  // Normal mode relies on the far end idling the line high.
  assign rx_line = ir_sel ? !(dec_in || stretch != 4'h0) : pin_s2[0];

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} scp_rx_type;
  scp_rx_type rx_state;
  logic [7:0] rx_shift;
  logic [3:0] rx_sub;
  logic [2:0] rx_bit;
  logic       rx_push;
  logic       buf_in_ready;
  logic       overrun;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_state <= RX_IDLE;
      rx_shift <= 8'h00;
      rx_sub   <= 4'h0;
      rx_bit   <= 3'h0;
      rx_push  <= 1'b0;
    end else begin
      rx_push <= 1'b0;
      if (tick16) begin
        rx_sub <= rx_sub + 4'h1;
        case (rx_state)
          RX_IDLE: begin
            rx_sub <= 4'h0;
            if (!rx_line) begin
              rx_state <= RX_START;
            end
          end
          RX_START: begin
            if (rx_sub == TICKS_HALF) begin
              rx_sub   <= 4'h0;
              rx_bit   <= 3'h0;
              rx_state <= rx_line ? RX_IDLE : RX_DATA;
            end
          end
          RX_DATA: begin
            if (rx_sub == TICKS_LAST) begin
              rx_sub   <= 4'h0;
              rx_shift <= {rx_line, rx_shift[7:1]};
              rx_bit   <= rx_bit + 3'h1;
              if (rx_bit == 3'h7) begin
                rx_state <= RX_STOP;
              end
            end
          end
          RX_STOP: begin
            if (rx_sub == TICKS_LAST) begin
              rx_push  <= rx_line;
              rx_state <= RX_IDLE;
            end
          end
          default: rx_state <= RX_IDLE;
        endcase
      end
    end
  end

  // Receive buffer; a full buffer refuses the word and flags overrun.
  logic [7:0]    buf_mem [BUF_DEPTH];
  logic [PW-1:0] buf_wp;
  logic [PW-1:0] buf_rp;
  logic [PW:0]   buf_cnt;
  logic          buf_valid;
  logic          buf_pop;
  logic          buf_wr;
  assign buf_in_ready = (buf_cnt != (PW+1)'(BUF_DEPTH));
  assign buf_valid    = (buf_cnt != '0);
  assign buf_wr       = rx_push && buf_in_ready;
  always_ff @(posedge clk) begin
    if (buf_wr) begin
      buf_mem[buf_wp] <= rx_shift;
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      buf_wp  <= '0;
      buf_rp  <= '0;
      buf_cnt <= '0;
    end else begin
      buf_wp  <= buf_wp + PW'(buf_wr);
      buf_rp  <= buf_rp + PW'(buf_pop);
      buf_cnt <= buf_cnt + (PW+1)'(buf_wr) - (PW+1)'(buf_pop);
    end
  end

  // AXI4-Lite write path: address and data are taken in either order.
  logic       aw_got;
  logic       w_got;
  logic [7:0] aw_addr;
  logic [7:0] w_byte;
  logic       w_lane0;
  logic       wr_go;
  logic       st_clr_ovr;
  assign s_axi_awready = !aw_got && !s_axi_bvalid;
  assign s_axi_wready  = !w_got && !s_axi_bvalid;
  assign wr_go   = aw_got && w_got && !s_axi_bvalid;
  assign wr_data = wr_go && w_lane0 && aw_addr == OFS_DATA;
  assign st_clr_ovr = wr_go && w_lane0 && aw_addr == OFS_STATUS
                      && w_byte[ST_OVR];
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a <= OFS_STATUS) && (a[1:0] == 2'h0);
  endfunction
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      aw_got  <= 1'b0;
      w_got   <= 1'b0;
      aw_addr <= 8'h00;
      w_byte  <= 8'h00;
      w_lane0 <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got  <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got   <= 1'b1;
        w_byte  <= s_axi_wdata[7:0];
        w_lane0 <= s_axi_wstrb[0];
      end
      if (wr_go) begin
        aw_got <= 1'b0;
        w_got  <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      modem_control              <= MODEM_RST;
      feature_control            <= FEATURE_RST;
      alternate_function_control <= ALTFUNC_RST;
      divisor                    <= DIVISOR_RST;
    end else if (wr_go && w_lane0) begin
      case (aw_addr)
        OFS_MODEM:   modem_control              <= w_byte;
        OFS_FEATURE: feature_control            <= w_byte;
        OFS_ALTFUNC: alternate_function_control <= w_byte;
        OFS_DIVISOR: divisor[7:0]               <= w_byte;
        default: ;
      endcase
    end
  end

  // Overrun is sticky; a new overrun beats a simultaneous clear.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      overrun <= 1'b0;
    end else if (rx_push && !buf_in_ready) begin
      overrun <= 1'b1;
    end else if (st_clr_ovr) begin
      overrun <= 1'b0;
    end
  end

  // AXI4-Lite read path; reading the data word pops the buffer.
  logic [7:0] rd_byte;
  assign s_axi_arready = !s_axi_rvalid;
  assign buf_pop = s_axi_arvalid && s_axi_arready
                   && s_axi_araddr == OFS_DATA && buf_valid;
  always_comb begin
    rd_byte = 8'h00;
    case (s_axi_araddr)
      OFS_DATA:    rd_byte = buf_valid ? buf_mem[buf_rp] : 8'h00;
      OFS_MODEM:   rd_byte = modem_control;
      OFS_FEATURE: rd_byte = feature_control;
      OFS_ALTFUNC: rd_byte = alternate_function_control;
      OFS_DIVISOR: rd_byte = divisor[7:0];
      OFS_STATUS:  rd_byte = {~pin_s2[4:1], overrun, tx_busy, tx_full,
                              buf_valid};
      default:     rd_byte = 8'h00;
    endcase
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h000000, rd_byte};
      s_axi_rresp  <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Modem outputs and the multi-function pin; code 3 falls back to OP2.
  logic next_mf;
  always_comb begin
    case (mf_sel)
      MF_BAUD:  next_mf = baud_clk;
      MF_RXRDY: next_mf = !buf_valid;
      default:  next_mf = !modem_control[MC_OP2];
    endcase
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      multi_function_out_n_chan_a <= 1'b1;
      request_to_send_n_chan_a    <= 1'b1;
      terminal_ready_n_chan_a     <= 1'b1;
    end else begin
      multi_function_out_n_chan_a <= next_mf;
      request_to_send_n_chan_a    <= !modem_control[MC_RTS];
      terminal_ready_n_chan_a     <= !modem_control[MC_DTR];
    end
  end

  // Checks.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  logic seen;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      seen <= 1'b0;
    end else begin
      seen <= 1'b1;
    end
  end
  sequence s_zero_bit_start;
    ir_sel && tx_busy && !tx_shift[0] && tx_sub == 4'h0;
  endsequence
  sequence s_ir_pin_low;
    ir_sel && feature_control[FC_IRINV] && !pin_s2[0];
  endsequence
  tx_idle_high_a: assert property (
    !$past(ir_sel) && !$past(tx_busy) |-> serial_out_chan_a)
    else $error("normal idle transmit not high");
  ir_idle_low_a: assert property (
    $past(ir_sel) && !$past(tx_busy) |-> !serial_out_chan_a)
    else $error("infrared idle transmit not low");
  ir_pulse_out_a: assert property (
    s_zero_bit_start ##0 ir_sel[*2] |=> serial_out_chan_a)
    else $error("infrared zero bit gave no pulse");
  ir_invert_dec_a: assert property (
    s_ir_pin_low |=> stretch == TICKS_LAST && !rx_line)
    else $error("inverted pulse did not reach decoder");
  mf_op2_out_a: assert property (
    $past(mf_sel) == MF_OP2 |-> multi_function_out_n_chan_a
                               == !$past(modem_control[MC_OP2]))
    else $error("general output two mismatch");
  mf_spare_code_a: assert property (
    $past(mf_sel) == 2'h3 |-> multi_function_out_n_chan_a
                             == !$past(modem_control[MC_OP2]))
    else $error("unused selector not shown as output two");
  mf_baud_out_a: assert property (
    $past(mf_sel) == MF_BAUD |-> multi_function_out_n_chan_a
                                == $past(baud_clk))
    else $error("baud clock not on multi-function pin");
  mf_rxrdy_out_a: assert property (
    $past(mf_sel) == MF_RXRDY && $past(buf_valid)
    |-> !multi_function_out_n_chan_a)
    else $error("receive ready not low with data waiting");
  op2_reset_a: assert property (
    !seen |-> !modem_control[MC_OP2] && multi_function_out_n_chan_a)
    else $error("output two not cleared by reset");
  // The line must stay low after the pulse ends, which only the stretch does.
  ir_rx_decode_a: assert property (
    ir_sel && !feature_control[FC_IRINV] && $stable(feature_control[FC_IRINV])
    && $fell(pin_s2[0]) |-> !rx_line)
    else $error("infrared pulse not decoded as zero");
endmodule // scp_channel

/* dv/scp_line_model.sv */
// Purpose: Far-side serial line model for one channel.
// Assumes: 8N1 frames, LSB first, BIT_CLKS clocks to a bit.
// Notes: Infrared zero bits are pulses of three sixteenths of a bit.
`timescale 1ns/1ps
module scp_line_model #(
  parameter int BIT_CLKS = 64
) (
  input  wire logic       clk,
  input  wire logic       line_in,
  output logic            line_out,
  output logic [3:0]      modem_n
);
  logic ir_mode = 1'b0;
  logic ir_inv  = 1'b0;

  initial begin
    line_out = 1'b1;
    modem_n  = 4'hf;
  end

  // Between frames the pin rests at its idle level, never at the last bit.
  task automatic idle();
    line_out <= ir_mode ? ir_inv : 1'b1;
  endtask

  task automatic set_mode(input logic ir, input logic inv);
    ir_mode = ir;
    ir_inv  = inv;
    idle();
  endtask

  task automatic set_modem(input logic [3:0] v);
    modem_n <= v;
  endtask

  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int k = 0; k < 10; k++) begin
      for (int c = 0; c < BIT_CLKS; c++) begin
        @(posedge clk);
        if (ir_mode)
          line_out <= ir_inv ^ (!f[k] && c < 3 * BIT_CLKS / 16);
        else
          line_out <= f[k];
      end
    end
    @(posedge clk);
    idle();
  endtask

  // Samples each bit in its middle; ok stays low if no start bit comes.
  task automatic recv_byte(output logic [7:0] b, output logic ok);
    int i;
    ok = 1'b0;
    b  = 8'h00;
    for (i = 0; i < 4 * BIT_CLKS && line_in; i++) @(posedge clk);
    if (!line_in) begin
      ok = 1'b1;
      repeat (BIT_CLKS / 2) @(posedge clk);
      for (int k = 0; k < 8; k++) begin
        repeat (BIT_CLKS) @(posedge clk);
        b[k] = line_in;
      end
    end
  endtask

  task automatic count_rises(input int clks, output int n);
    logic last;
    n    = 0;
    last = line_in;
    repeat (clks) begin
      @(posedge clk);
      if (line_in && !last) n++;
      last = line_in;
    end
  endtask
endmodule // scp_line_model

/* dv/serial_channel_pin_behaviour_test.sv */
// Purpose: Self-checking bench for the serial channel pin block.
// Assumes: Divisor 3 gives four clocks a tick, 64 clocks a bit.
// Notes: Registers are reached only through the AXI4-Lite tasks.
`timescale 1ns/1ps
module serial_channel_pin_behaviour_test;
  import scp_pkg::*;
  localparam int BIT_CLKS = 64;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'h0;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic        rx_pin, tx_pin, rts_n, dtr_n, mf_n;
  logic [3:0]  mdm_n;
  int          n_fail = 0;
  int          comparisons = 0;

  always #25 clk = ~clk;

  scp_channel dut (
    .clk(clk), .arst_n(arst_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .serial_in_chan_a(rx_pin), .serial_out_chan_a(tx_pin),
    .request_to_send_n_chan_a(rts_n), .terminal_ready_n_chan_a(dtr_n),
    .clear_to_send_n_chan_a(mdm_n[0]), .set_ready_n_chan_a(mdm_n[1]),
    .carrier_detect_n_chan_a(mdm_n[2]),
    .ring_indicator_n_chan_a(mdm_n[3]),
    .multi_function_out_n_chan_a(mf_n)
  );

  scp_line_model #(.BIT_CLKS(BIT_CLKS)) lm (
    .clk(clk), .line_in(tx_pin), .line_out(rx_pin), .modem_n(mdm_n)
  );

  task automatic results();
    if (n_fail == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    int   i;
    logic aw, w;
    aw = 1'b0;
    w  = 1'b0;
    awaddr  <= a;
    wdata   <= {24'h0, d};
    wstrb   <= 4'hf;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (i = 0; i < 200 && !(aw && w); i++) begin
      @(posedge clk);
      if (!aw && awready) begin
        aw = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w && wready) begin
        w = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do begin
      @(posedge clk);
      i++;
    end while (!bvalid && i < 200);
    bready <= 1'b0;
    @(posedge clk);
    if (i >= 200) begin
      n_fail++;
      results();
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    int i;
    i = 0;
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge clk);
      i++;
    end while (!arready && i < 200);
    arvalid <= 1'b0;
    do begin
      @(posedge clk);
      i++;
    end while (!rvalid && i < 200);
    rready <= 1'b0;
    d = rdata;
    r = rresp;
    @(posedge clk);
    if (i >= 200) begin
      n_fail++;
      results();
    end
  endtask

  task automatic rchk(string what, logic [7:0] a, logic [31:0] exp,
                      logic [1:0] rexp = RESP_OKAY);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    check(what, exp, d);
    check({what, " resp"}, {30'h0, rexp}, {30'h0, r});
  endtask

  initial begin
    logic [7:0]  b;
    logic        ok;
    int          n;
    logic [31:0] d;
    logic [1:0]  r;
    repeat (2) @(posedge clk);
    check("tx in reset", 32'h1, {31'h0, tx_pin});
    check("mf in reset", 32'h1, {31'h0, mf_n});
    @(posedge clk);
    arst_n <= 1'b1;
    rchk("modem reset", OFS_MODEM, {24'h0, MODEM_RST});
    rchk("feature reset", OFS_FEATURE, {24'h0, FEATURE_RST});
    rchk("altfunc reset", OFS_ALTFUNC, {24'h0, ALTFUNC_RST});
    rchk("unmapped", 8'h18, 32'h0, RESP_SLVERR);
    wr(OFS_DIVISOR, 8'h03);
    wr(OFS_MODEM, 8'h0b);
    check("rts", 32'h0, {31'h0, rts_n});
    check("dtr", 32'h0, {31'h0, dtr_n});
    check("op2 set", 32'h0, {31'h0, mf_n});
    wr(OFS_ALTFUNC, 8'h06);
    check("op2 sel3", 32'h0, {31'h0, mf_n});
    wr(OFS_MODEM, 8'h00);
    check("op2 clear", 32'h1, {31'h0, mf_n});
    wr(OFS_ALTFUNC, {5'h0, MF_BAUD, 1'b0});
    ok = mf_n;
    n  = 0;
    repeat (40) begin
      @(posedge clk);
      if (mf_n && !ok) n++;
      ok = mf_n;
    end
    check("baud edges", 32'd10, n);
    wr(OFS_ALTFUNC, {5'h0, MF_RXRDY, 1'b0});
    check("rxrdy idle", 32'h1, {31'h0, mf_n});
    fork
      lm.recv_byte(b, ok);
      wr(OFS_DATA, 8'h5a);
    join
    check("tx byte", 32'h15a, {23'h0, ok, b});
    repeat (2 * BIT_CLKS) @(posedge clk);
    check("tx idle", 32'h1, {31'h0, tx_pin});
    lm.send_byte(8'hc3);
    check("rxrdy data", 32'h0, {31'h0, mf_n});
    lm.set_modem(4'he);
    lm.send_byte(8'h96);
    lm.send_byte(8'h11);
    rchk("status", OFS_STATUS, 32'h19);
    rchk("rx first", OFS_DATA, 32'hc3);
    rchk("rx second", OFS_DATA, 32'h96);
    rchk("rx empty", OFS_DATA, 32'h0);
    check("rxrdy drained", 32'h1, {31'h0, mf_n});
    wr(OFS_STATUS, 8'h08);
    rchk("status clear", OFS_STATUS, 32'h10);
    wr(OFS_MODEM, 8'h40);
    check("ir idle", 32'h0, {31'h0, tx_pin});
    // Leaving the normal idle level can finish a junk word; the transmit
    // frame below gives it time to land before the buffer is drained.
    lm.set_mode(1'b1, 1'b0);
    fork
      lm.count_rises(11 * BIT_CLKS, n);
      wr(OFS_DATA, 8'h55);
    join
    check("ir pulses", 32'd5, n);
    check("ir idle after", 32'h0, {31'h0, tx_pin});
    rd(OFS_DATA, d, r);
    rd(OFS_DATA, d, r);
    lm.send_byte(8'h3c);
    rchk("ir rx", OFS_DATA, 32'h3c);
    // The pin and the inversion bit cannot change together; drain any junk.
    lm.set_mode(1'b1, 1'b1);
    wr(OFS_FEATURE, 8'h04);
    repeat (12 * BIT_CLKS) @(posedge clk);
    rd(OFS_DATA, d, r);
    rd(OFS_DATA, d, r);
    lm.send_byte(8'ha5);
    rchk("ir inv rx", OFS_DATA, 32'ha5);
    wr(OFS_MODEM, 8'h48);
    arst_n <= 1'b0;
    repeat (3) @(posedge clk);
    check("tx in reset 2", 32'h1, {31'h0, tx_pin});
    arst_n <= 1'b1;
    rchk("modem reset 2", OFS_MODEM, {24'h0, MODEM_RST});
    check("mf after reset", 32'h1, {31'h0, mf_n});
    results();
  end
endmodule // serial_channel_pin_behaviour_test
